// >>> verilog/mpc_consts.vh
// constants for motor pin control and fault report block
`ifndef MPC_CONSTS_VH
`define MPC_CONSTS_VH
// speed source select encodings
`define MPC_SRC_ANALOG      2'h0
`define MPC_SRC_PWM         2'h1
`define MPC_SRC_I2C         2'h2
`define MPC_SRC_FREQ        2'h3
// buck voltage select encodings
`define MPC_BUCK_3V3        2'h0
`define MPC_BUCK_4V0        2'h1
`define MPC_BUCK_5V0        2'h2
`define MPC_BUCK_5V7        2'h3
// buck current limit select
`define MPC_CL_600MA        1'h0
`define MPC_CL_150MA        1'h1
// motor state codes
`define MPC_ST_IDLE         3'h0
`define MPC_ST_RUN          3'h1
`define MPC_ST_RAMP         3'h2
`define MPC_ST_BRAKE        3'h3
`define MPC_ST_COAST        3'h4
`define MPC_ST_RESTART      3'h5
// reset values
`define MPC_SPEED_RST       16'h0000
`define MPC_PHASE_RST       2'h0
// ramp step per cycle while slowing down
`define MPC_RAMP_STEP       16'h0001
// restart sequence length in cycles
`define MPC_RESTART_CYC     8'h10
`endif

// >>> verilog/mpc_top.v
// motor control pin handling, fault routing and speed pulse logic
`timescale 1ns/1ps
`include "mpc_consts.vh"

// =====================================================================
module mpc_top (
   input  wire        clk_in,
   input  wire        nrst_in,
   input  wire        brake_pin_in,
   input  wire        dir_pin_in,
   input  wire        drive_disable_input_in,
   input  wire        brake_ovr_en_in,
   input  wire        brake_ovr_val_in,
   input  wire        dir_ovr_en_in,
   input  wire        dir_ovr_val_in,
   input  wire [15:0] brake_speed_thr_in,
   input  wire [1:0]  speed_src_sel_in,
   input  wire [15:0] pin_duty_in,
   input  wire [15:0] pin_freq_in,
   input  wire [15:0] pin_analog_in,
   input  wire [15:0] reg_speed_cmd_in,
   input  wire        actionable_fault_in,
   input  wire        report_fault_in,
   input  wire        alarm_pin_en_in,
   input  wire        pullup_en_stored_in,
   input  wire [1:0]  buck_sel_in,
   input  wire        buck_current_limit_select_in,
   input  wire        regulator_sequencing_disable_in,
   output reg  [1:0]  phase_out,
   output reg         outputs_enable_out,
   output reg  [15:0] motor_speed_out,
   output reg  [2:0]  motor_state_out,
   output reg         sleep_out,
   output reg         core_active_out,
   output reg         no_motor_flag_out,
   output reg         fault_out_n,
   output reg         alarm_out,
   output reg         alarm_oe_out,
   output reg         speed_pulse_output_out,
   output reg         pullup_active_out,
   output reg  [1:0]  buck_vsel_out,
   output reg         buck_current_limit_select_150ma_out,
   output reg         seq_enable_out,
   output reg  [7:0]  fault_status_out
);

   // =================================================================
   // input synchronisers
   wire brk_sync;
   wire dir_sync;
   wire drv_sync;

   mpc_sync2 #(.WIDTH(1)) u_mpc_sync2_brk (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .d_in    (brake_pin_in),
      .q_out   (brk_sync)
   );

   mpc_sync2 #(.WIDTH(1)) u_mpc_sync2_dir (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .d_in    (dir_pin_in),
      .q_out   (dir_sync)
   );

   mpc_sync2 #(.WIDTH(1)) u_mpc_sync2_drv (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .d_in    (drive_disable_input_in),
      .q_out   (drv_sync)
   );

   wire brake_req = brake_ovr_en_in ? brake_ovr_val_in : brk_sync;
   wire dir_fwd   = dir_ovr_en_in ? dir_ovr_val_in : dir_sync;
   wire drv_off   = drv_sync;

   // =================================================================
   // speed command source select
   reg [15:0] speed_cmd;

   always @* begin
      case (speed_src_sel_in)
         `MPC_SRC_ANALOG: speed_cmd = pin_analog_in;
         `MPC_SRC_PWM:    speed_cmd = pin_duty_in;
         `MPC_SRC_I2C:    speed_cmd = reg_speed_cmd_in;
         `MPC_SRC_FREQ:   speed_cmd = pin_freq_in;
         default:         speed_cmd = pin_analog_in;
      endcase
   end

   // sleep request from speed command alone; drive disable still ends sleep by moving IDLE to COAST
   wire sleep_req = (speed_cmd == 16'h0000);

   // =================================================================
   // motor state machine
   reg [2:0]  state_r;
   reg [2:0]  state_nxt;
   reg [15:0] speed_r;
   reg [15:0] speed_nxt;
   reg [7:0]  rst_cnt_r;
   reg [7:0]  rst_cnt_nxt;

   always @* begin
      state_nxt   = state_r;
      speed_nxt   = speed_r;
      rst_cnt_nxt = rst_cnt_r;
      case (state_r)
         `MPC_ST_IDLE: begin
            speed_nxt = `MPC_SPEED_RST;
            if (drv_off)
               state_nxt = `MPC_ST_COAST;
            else if (!sleep_req) begin
               state_nxt   = `MPC_ST_RESTART;
               rst_cnt_nxt = 8'h00;
            end
         end
         `MPC_ST_RUN: begin
            speed_nxt = speed_cmd;
            if (drv_off)
               state_nxt = `MPC_ST_COAST;
            else if (brake_req)
               state_nxt = `MPC_ST_RAMP;
            else if (sleep_req)
               state_nxt = `MPC_ST_IDLE;
         end
         `MPC_ST_RAMP: begin
            if (drv_off)
               state_nxt = `MPC_ST_COAST;
            else if (!brake_req)
               state_nxt = `MPC_ST_RUN;
            else if (speed_r <= brake_speed_thr_in)
               state_nxt = `MPC_ST_BRAKE;
            else
               speed_nxt = speed_r - `MPC_RAMP_STEP;
         end
         `MPC_ST_BRAKE: begin
            speed_nxt = `MPC_SPEED_RST;
            if (drv_off)
               state_nxt = `MPC_ST_COAST;
            else if (!brake_req) begin
               state_nxt   = `MPC_ST_RESTART;
               rst_cnt_nxt = 8'h00;
            end
         end
         `MPC_ST_COAST: begin
            speed_nxt = `MPC_SPEED_RST;
            if (!drv_off) begin
               state_nxt   = `MPC_ST_RESTART;
               rst_cnt_nxt = 8'h00;
            end
         end
         `MPC_ST_RESTART: begin
            speed_nxt   = `MPC_SPEED_RST;
            rst_cnt_nxt = rst_cnt_r + 8'h01;
            if (drv_off)
               state_nxt = `MPC_ST_COAST;
            else if (rst_cnt_r == `MPC_RESTART_CYC - 8'h01)
               state_nxt = `MPC_ST_RUN;
         end
         default: begin
            state_nxt = `MPC_ST_IDLE;
            speed_nxt = `MPC_SPEED_RST;
         end
      endcase
   end

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_r   <= `MPC_ST_IDLE;
         speed_r   <= `MPC_SPEED_RST;
         rst_cnt_r <= 8'h00;
      end else begin
         state_r   <= state_nxt;
         speed_r   <= speed_nxt;
         rst_cnt_r <= rst_cnt_nxt;
      end
   end

   // =================================================================
   // commutation phase stepping and speed pulse accumulator
   reg  [15:0] phase_acc_r;
   reg  [15:0] pulse_acc_r;
   wire        spinning  = (state_r == `MPC_ST_RUN) || (state_r == `MPC_ST_RAMP);
   // carry out of the 16-bit sum marks one step
   wire [16:0] pulse_sum = {1'b0, pulse_acc_r} + {1'b0, speed_r};
   wire [16:0] phase_sum = {1'b0, phase_acc_r} + {1'b0, speed_r};

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         phase_acc_r            <= 16'h0000;
         pulse_acc_r            <= 16'h0000;
         phase_out              <= `MPC_PHASE_RST;
         speed_pulse_output_out <= 1'b0;
      end else begin
         if (spinning) begin
            phase_acc_r <= phase_sum[15:0];
            pulse_acc_r <= pulse_sum[15:0];
            if (phase_sum[16]) begin
               // forward A,B,C = 0,1,2; reverse A,C,B = 0,2,1
               if (dir_fwd)
                  phase_out <= (phase_out == 2'h2) ? 2'h0 : phase_out + 2'h1;
               else
                  phase_out <= (phase_out == 2'h0) ? 2'h2 : phase_out - 2'h1;
            end
            if (pulse_sum[16])
               speed_pulse_output_out <= ~speed_pulse_output_out;
         end else begin
            phase_acc_r            <= 16'h0000;
            pulse_acc_r            <= 16'h0000;
            speed_pulse_output_out <= 1'b0;
         end
      end
   end

   // =================================================================
   // status outputs
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         outputs_enable_out <= 1'b0;
         motor_speed_out    <= `MPC_SPEED_RST;
         motor_state_out    <= `MPC_ST_IDLE;
         sleep_out          <= 1'b0;
         core_active_out    <= 1'b0;
         no_motor_flag_out  <= 1'b0;
         fault_status_out   <= 8'h00;
      end else begin
         outputs_enable_out <= spinning && !drv_off;
         motor_speed_out    <= speed_r;
         motor_state_out    <= state_r;
         sleep_out          <= (state_r == `MPC_ST_IDLE) && sleep_req;
         core_active_out    <= 1'b1;
         no_motor_flag_out  <= (state_r == `MPC_ST_COAST);
         fault_status_out   <= {3'h0, drv_off, brake_req, no_motor_flag_out,
                                report_fault_in, actionable_fault_in};
      end
   end

   // =================================================================
   // fault routing to fault and alarm pins
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fault_out_n  <= 1'b1;
         alarm_out    <= 1'b0;
         alarm_oe_out <= 1'b0;
      end else begin
         if (alarm_pin_en_in) begin
            alarm_oe_out <= 1'b1;
            alarm_out    <= actionable_fault_in | report_fault_in;
            fault_out_n  <= ~actionable_fault_in;
         end else begin
            // alarm released, pin floats while its enable is low
            alarm_oe_out <= 1'b0;
            alarm_out    <= 1'b0;
            fault_out_n  <= ~(actionable_fault_in | report_fault_in);
         end
      end
   end

   // =================================================================
   // pull-up setting, latched once after power-up
   reg pullup_taken_r;

   // later changes of the stored setting wait for the next power cycle
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pullup_active_out <= 1'b0;
         pullup_taken_r    <= 1'b0;
      end else begin
         if (!pullup_taken_r) begin
            pullup_taken_r    <= 1'b1;
            pullup_active_out <= pullup_en_stored_in;
         end
      end
   end

   // =================================================================
   // regulator settings
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         buck_vsel_out     <= `MPC_BUCK_3V3;
         buck_current_limit_select_150ma_out <= `MPC_CL_600MA;
         seq_enable_out    <= 1'b0;
      end else begin
         buck_vsel_out     <= buck_sel_in;
         buck_current_limit_select_150ma_out <= buck_current_limit_select_in;
         // sequencing only for the two higher buck voltages
         seq_enable_out    <= !regulator_sequencing_disable_in &&
                              ((buck_sel_in == `MPC_BUCK_5V0) ||
                               (buck_sel_in == `MPC_BUCK_5V7));
      end
   end

endmodule // mpc_top

// =====================================================================
// two-flop synchroniser for asynchronous pins
module mpc_sync2 #(
   parameter WIDTH = 1
) (
   input  wire             clk_in,
   input  wire             nrst_in,
   input  wire [WIDTH-1:0] d_in,
   output wire [WIDTH-1:0] q_out
);

   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   // nothing outside reads the first stage
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_r <= {WIDTH{1'b0}};
         sync_r <= {WIDTH{1'b0}};
      end else begin
         meta_r <= d_in;
         sync_r <= meta_r;
      end
   end

   assign q_out = sync_r;

endmodule // mpc_sync2

// >>> verif/mpc_checker.sv
// assertions for motor pin control and fault report block
`timescale 1ns/1ps
`include "mpc_consts.vh"
module mpc_checker (
   input wire logic        clk_in,
   input wire logic        nrst_in,
   input wire logic        drive_disable_input_in,
   input wire logic        actionable_fault_in,
   input wire logic        report_fault_in,
   input wire logic        alarm_pin_en_in,
   input wire logic [1:0]  buck_sel_in,
   input wire logic        regulator_sequencing_disable_in,
   input wire logic [15:0] brake_speed_thr_in,
   input wire logic [15:0] motor_speed_out,
   input wire logic [2:0]  motor_state_out,
   input wire logic        outputs_enable_out,
   input wire logic        no_motor_flag_out,
   input wire logic        sleep_out,
   input wire logic        fault_out_n,
   input wire logic        alarm_out,
   input wire logic        alarm_oe_out,
   input wire logic        seq_enable_out
);
   // ==========
   // properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   act_fault_a: assert property (actionable_fault_in |=> !fault_out_n)
      else $error("fault pin high on actionable fault");
   report_only_a: assert property (alarm_pin_en_in && report_fault_in
      && !actionable_fault_in |=> fault_out_n && alarm_out && alarm_oe_out)
      else $error("report-only fault misrouted");
   alarm_hiz_a: assert property (!alarm_pin_en_in && report_fault_in
      |=> !fault_out_n && !alarm_oe_out) else $error("disabled alarm misrouted");
   coast_off_a: assert property (motor_state_out == `MPC_ST_COAST
      |=> !outputs_enable_out) else $error("bridge driven while coasting");
   coast_flag_a: assert property (motor_state_out == `MPC_ST_COAST
      |-> no_motor_flag_out && !sleep_out) else $error("coast flags wrong");
   drv_sync_a: assert property (drive_disable_input_in [*4]
      |=> motor_state_out == `MPC_ST_COAST) else $error("no coast after drive disable");
   brake_entry_a: assert property ($rose(motor_state_out == `MPC_ST_BRAKE)
      |-> motor_speed_out <= brake_speed_thr_in) else $error("brake above threshold");
   seq_en_a: assert property (1'b1 |=> seq_enable_out ==
      ($past(buck_sel_in[1]) && !$past(regulator_sequencing_disable_in)))
      else $error("sequencing enable wrong");
   cover property (motor_state_out == `MPC_ST_BRAKE);
   cover property (motor_state_out == `MPC_ST_COAST);
   cover property (alarm_out && fault_out_n);
endmodule // mpc_checker

bind mpc_top mpc_checker u_mpc_checker (.clk_in(clk_in), .nrst_in(nrst_in),
   .drive_disable_input_in(drive_disable_input_in), .actionable_fault_in(actionable_fault_in),
   .report_fault_in(report_fault_in), .alarm_pin_en_in(alarm_pin_en_in),
   .buck_sel_in(buck_sel_in), .brake_speed_thr_in(brake_speed_thr_in),
   .regulator_sequencing_disable_in(regulator_sequencing_disable_in),
   .motor_speed_out(motor_speed_out), .motor_state_out(motor_state_out),
   .outputs_enable_out(outputs_enable_out), .no_motor_flag_out(no_motor_flag_out),
   .sleep_out(sleep_out), .fault_out_n(fault_out_n), .alarm_out(alarm_out),
   .alarm_oe_out(alarm_oe_out), .seq_enable_out(seq_enable_out));

// >>> verif/mpc_ctrl_model.sv
// model of the external controller on the control pins
`timescale 1ns/1ps
module mpc_ctrl_model (
   input  wire       clk_in,
   output reg  [6:0] pins_out
);
   // {brake, dir, drive off, brake ovr en, val, dir ovr en, val}
   initial pins_out = 7'h00;
   task drive(input [6:0] v);
      begin
         @(posedge clk_in);
         pins_out <= v;
      end
   endtask
endmodule // mpc_ctrl_model

// >>> verif/mpc_top_tb.sv
// self-checking bench for motor pin control and fault report block
`timescale 1ns/1ps
`include "mpc_consts.vh"
module mpc_top_tb;
   reg         clk_in = 1'b0;
   reg         nrst_in = 1'b0;
   reg  [15:0] cmd [0:3];
   reg  [1:0]  src = 2'h0;
   reg  [1:0]  bsel = 2'h0;
   reg  [2:0]  flt = 3'h0;
   reg  [2:0]  psv = 3'h4;
   reg  [15:0] thr = 16'h0F00;
   wire [7:0]  fs;
   wire [6:0]  pins;
   wire [15:0] spd;
   wire [2:0]  st;
   wire [1:0]  ph, bv;
   wire        oe, slp, core, nm, fn, al, aoe, fg, pu, cl, seq;
   integer     errors = 0, n_compared = 0, i, j, k;
   mpc_ctrl_model u_mpc_ctrl_model (.clk_in(clk_in), .pins_out(pins));
   mpc_top u_mpc_top (.clk_in(clk_in), .nrst_in(nrst_in), .brake_pin_in(pins[6]),
      .dir_pin_in(pins[5]), .drive_disable_input_in(pins[4]), .brake_ovr_en_in(pins[3]),
      .brake_ovr_val_in(pins[2]), .dir_ovr_en_in(pins[1]), .dir_ovr_val_in(pins[0]),
      .brake_speed_thr_in(thr), .speed_src_sel_in(src), .pin_analog_in(cmd[0]),
      .pin_duty_in(cmd[1]), .reg_speed_cmd_in(cmd[2]), .pin_freq_in(cmd[3]),
      .actionable_fault_in(flt[1]), .report_fault_in(flt[0]), .alarm_pin_en_in(flt[2]),
      .pullup_en_stored_in(psv[2]), .buck_sel_in(bsel), .buck_current_limit_select_in(psv[1]),
      .regulator_sequencing_disable_in(psv[0]), .phase_out(ph), .outputs_enable_out(oe),
      .motor_speed_out(spd), .motor_state_out(st), .sleep_out(slp), .core_active_out(core),
      .no_motor_flag_out(nm), .fault_out_n(fn), .alarm_out(al), .alarm_oe_out(aoe),
      .speed_pulse_output_out(fg), .pullup_active_out(pu), .buck_vsel_out(bv),
      .buck_current_limit_select_150ma_out(cl), .seq_enable_out(seq), .fault_status_out(fs));
   initial forever #20 clk_in = ~clk_in;
   // ==========
   // helpers
   task chk(input [127:0] what, input [15:0] e, input [15:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("mismatch %0s expected %h seen %h", what, e, g);
         end
      end
   endtask
   task close_out;
      begin
         if (errors == 0 && n_compared > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task wst(input [2:0] s);
      begin
         k = 0;
         while (st !== s && k < 9000) begin
            @(posedge clk_in);
            #1 k = k + 1;
         end
         chk("state", s, st);
      end
   endtask
   task t_dir(input [6:0] p, input [1:0] inc);
      reg [1:0] last;
      begin
         u_mpc_ctrl_model.drive(p);
         repeat (6) @(posedge clk_in);
         #1 last = ph;
         j = 0;
         repeat (400) begin
            @(posedge clk_in);
            #1 if (ph !== last) j = j + 1;
            if (ph !== last) chk("phase", (last + inc) % 3, ph);
            last = ph;
         end
         chk("steps", 1, j > 0);
      end
   endtask
   // ==========
   // scenarios
   initial begin
      for (i = 0; i < 4; i = i + 1) cmd[i] = 16'h0;
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      #1 chk("sleep", 1, slp);
      chk("core", 1, core);
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge clk_in);
         src <= i[1:0];
         psv <= 3'h0;
         for (j = 0; j < 4; j = j + 1) cmd[j] <= (i == j) ? 16'h0 : 16'h1000;
         repeat (6) @(posedge clk_in);
         #1 chk("unselected", 1, slp);
      end
      chk("pullup", 1, pu);
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge clk_in);
         flt <= i[2:0];
         repeat (2) @(posedge clk_in);
         #1 chk("fault_n", !(flt[1] | (!flt[2] & flt[0])), fn);
         chk("alarm_oe", flt[2], aoe);
         if (flt[2]) chk("alarm", flt[1] | flt[0], al);
      end
      for (i = 0; i < 16; i = i + 1) begin
         @(posedge clk_in);
         flt <= 3'h0;
         bsel <= i[3:2];
         psv <= {1'b0, i[1:0]};
         repeat (2) @(posedge clk_in);
         #1 chk("vsel", bsel, bv);
         chk("limit", psv[1], cl);
         chk("seq", bsel[1] & !psv[0], seq);
      end
      @(posedge clk_in);
      src <= `MPC_SRC_PWM;
      cmd[1] <= 16'h1000;
      wst(`MPC_ST_RUN);
      while (spd !== 16'h1000 && k < 9000) begin
         @(posedge clk_in);
         #1 k = k + 1;
      end
      chk("awake", 0, slp);
      i = 0;
      j = fg;
      repeat (1024) begin
         @(posedge clk_in);
         #1 if (fg !== j[0]) i = i + 1;
         j = fg;
      end
      chk("pulse_rate", 1, i >= 63 && i <= 65);
      t_dir(7'h00, 2'h2);
      t_dir(7'h22, 2'h2);
      t_dir(7'h03, 2'h1);
      t_dir(7'h20, 2'h1);
      u_mpc_ctrl_model.drive(7'h30);
      repeat (2) @(posedge clk_in);
      #1 chk("sync", `MPC_ST_RUN, st);
      wst(`MPC_ST_COAST);
      repeat (2) @(posedge clk_in);
      #1 chk("drive_on", 0, oe);
      chk("no_motor", 1, nm);
      chk("no_sleep", 0, slp);
      chk("fault_status", 16'h0014, fs);
      u_mpc_ctrl_model.drive(7'h20);
      wst(`MPC_ST_RESTART);
      wst(`MPC_ST_RUN);
      chk("restart_len", 16, k);
      @(posedge clk_in);
      thr <= 16'h0F80;
      u_mpc_ctrl_model.drive(7'h60);
      wst(`MPC_ST_BRAKE);
      chk("brake_speed", 1, spd <= thr);
      u_mpc_ctrl_model.drive(7'h2C);
      repeat (40) @(posedge clk_in);
      #1 chk("held", `MPC_ST_BRAKE, st);
      chk("brake_status", 16'h0008, fs);
      u_mpc_ctrl_model.drive(7'h68);
      wst(`MPC_ST_RESTART);
      close_out;
   end
   initial begin
      #(40 * 40000);
      errors = errors + 1;
      close_out;
   end
endmodule // mpc_top_tb
